// >>> mct_timer.sv
/*
  Match and capture timer/counter with a 32-bit prescaler and an Avalon-MM slave.
  Assumes the count clock and capture pins are asynchronous to mclk and slower than half its rate.
*/
//
// Contract
// - Count system clock ticks or edges of the external count input, as selected.
// - The 32-bit counter advances through a 32-bit programmable prescaler.
// - Four 32-bit match values are compared against the running count.
// - A match may let counting continue, raising a request only when enabled.
// - A match may halt the counter, optionally raising a request.
// - A match may clear the counter to zero, optionally raising a request.
// - Four capture channels load the count when their input transitions.
// - An enabled capture raises a request naming that capture channel.
// - Each match drives its output low, high, toggled or unchanged.
// - Software enables requests for each match and each capture separately.
`default_nettype none
module mct_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [mct_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [mct_pkg::DATA_W-1:0] writedata,
  output logic [mct_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // Pins
  input wire logic ext_count_in,
  input wire logic [mct_pkg::NUM_CH-1:0] capture_in,
  output logic [mct_pkg::NUM_CH-1:0] match_out,
  // Event requests
  output logic [2*mct_pkg::NUM_CH-1:0] irq_req
);

  // Byte lanes that are not enabled keep their old contents.
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Edge test on two synchronised samples, shared by the count input and the capture inputs.
  function automatic logic edge_seen(input logic prev, input logic cur, input logic on_rise,
                                     input logic on_fall);
    return (on_rise && !prev && cur) || (on_fall && prev && !cur);
  endfunction

  mct_pkg::mct_bus_state_t bus_state;
  mct_pkg::mct_ctrl_t ctrl;
  logic [31:0] count;
  logic [31:0] pre_limit;
  logic [31:0] pre_count;
  logic [11:0] match_ctrl;
  logic [11:0] capt_ctrl;
  logic [11:0] out_ctrl;
  logic [31:0] match_val [mct_pkg::NUM_CH];
  logic [31:0] capt_val [mct_pkg::NUM_CH];

  logic [2:0] ext_sync;
  logic [2:0] capt_sync [mct_pkg::NUM_CH];

  logic bus_take;
  logic wr_take;
  logic [31:0] next_count;
  logic [31:0] next_pre_count;
  logic tick;
  logic wrap;
  logic [mct_pkg::NUM_CH-1:0] hit;
  logic [mct_pkg::NUM_CH-1:0] capt_hit;
  logic any_reset;
  logic any_stop;
  logic [2*mct_pkg::NUM_CH-1:0] flag_set;
  logic [31:0] rd_mux;

  // The answer comes one cycle after the request so that read data always come from a flop.
  assign bus_take = (read || write) && (bus_state == mct_pkg::MCT_BUS_IDLE);
  assign wr_take = write && (bus_state == mct_pkg::MCT_BUS_ANSWER);

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_state <= mct_pkg::MCT_BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        mct_pkg::MCT_BUS_IDLE: begin
          if (read || write) begin
            bus_state <= mct_pkg::MCT_BUS_ANSWER;
            waitrequest <= 1'b0;
          end
        end
        mct_pkg::MCT_BUS_ANSWER: begin
          bus_state <= mct_pkg::MCT_BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= mct_pkg::MCT_BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Pin synchronisers; only the second and third stages are looked at.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_count_in};
    end
  end

  // One lane per channel: capture synchroniser, edge test, snapshot and match value.
  genvar gi;
  generate
    for (gi = 0; gi < mct_pkg::NUM_CH; gi++) begin : g_capt
      always_ff @(posedge mclk) begin
        if (rst) begin
          capt_sync[gi] <= 3'h0;
        end else begin
          capt_sync[gi] <= {capt_sync[gi][1:0], capture_in[gi]};
        end
      end

      assign capt_hit[gi] = edge_seen(capt_sync[gi][2], capt_sync[gi][1],
                                      capt_ctrl[gi*mct_pkg::CH_FIELD_W + mct_pkg::CC_RISE],
                                      capt_ctrl[gi*mct_pkg::CH_FIELD_W + mct_pkg::CC_FALL]);

      // Capture registers take no software write; only a capture on this channel loads them.
      always_ff @(posedge mclk) begin
        if (rst) begin
          capt_val[gi] <= mct_pkg::RST_WORD;
        end else if (capt_hit[gi]) begin
          capt_val[gi] <= count;
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          match_val[gi] <= mct_pkg::RST_WORD;
        end else if (wr_take && address == mct_pkg::OFF_MATCH0 + 8'(gi) * mct_pkg::OFF_STRIDE) begin
          match_val[gi] <= merge_be(match_val[gi], writedata, byteenable);
        end
      end

      // A match compares when the prescaler wraps, so each count value matches once.
      assign hit[gi] = wrap && (count == match_val[gi]);
    end
  endgenerate

  // Tick source and prescaler.
  always_comb begin
    tick = ctrl.run && !ctrl.hold;
    if (ctrl.ext_count) begin
      tick = tick && edge_seen(ext_sync[2], ext_sync[1], ctrl.edge_rise, ctrl.edge_fall);
    end
    wrap = tick && (pre_count >= pre_limit);
  end

  // Match actions are gathered apart from the tick logic so that no process reads its own output.
  always_comb begin
    any_reset = 1'b0;
    any_stop = 1'b0;
    for (int i = 0; i < mct_pkg::NUM_CH; i++) begin
      any_reset = any_reset || (hit[i] && match_ctrl[i*mct_pkg::CH_FIELD_W + mct_pkg::MC_RESET]);
      any_stop = any_stop || (hit[i] && match_ctrl[i*mct_pkg::CH_FIELD_W + mct_pkg::MC_STOP]);
    end
  end

  // Hold keeps both counters at zero until software releases it.
  always_comb begin
    next_pre_count = pre_count;
    if (ctrl.hold) begin
      next_pre_count = mct_pkg::RST_WORD;
    end else if (wrap) begin
      next_pre_count = mct_pkg::RST_WORD;
    end else if (tick) begin
      next_pre_count = pre_count + mct_pkg::ONE_WORD;
    end
  end

  // Reset beats stop; a stopped counter keeps the matched value.
  always_comb begin
    next_count = count;
    if (ctrl.hold) begin
      next_count = mct_pkg::RST_WORD;
    end else if (wr_take && address == mct_pkg::OFF_COUNT) begin
      next_count = merge_be(count, writedata, byteenable);
    end else if (any_reset) begin
      next_count = mct_pkg::RST_WORD;
    end else if (any_stop) begin
      next_count = count;
    end else if (wrap) begin
      next_count = count + mct_pkg::ONE_WORD;
    end
  end

  // Both counters share one register process so that they always move together.
  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= mct_pkg::RST_WORD;
      pre_count <= mct_pkg::RST_WORD;
    end else begin
      count <= next_count;
      pre_count <= next_pre_count;
    end
  end

  // Control registers; a stop on match clears the run bit over a software write.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= '0;
    end else begin
      if (wr_take && address == mct_pkg::OFF_CTRL && byteenable[0]) begin
        ctrl.run <= writedata[mct_pkg::CTRL_RUN];
        ctrl.hold <= writedata[mct_pkg::CTRL_HOLD];
        ctrl.ext_count <= writedata[mct_pkg::CTRL_EXT];
        ctrl.edge_rise <= writedata[mct_pkg::CTRL_EDGE_RISE];
        ctrl.edge_fall <= writedata[mct_pkg::CTRL_EDGE_FALL];
      end
      if (any_stop) begin
        ctrl.run <= 1'b0;
      end
    end
  end

  // A smaller limit written mid-count takes effect at once, since the wrap test is a compare.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_limit <= mct_pkg::RST_WORD;
    end else if (wr_take && address == mct_pkg::OFF_PRE_LIMIT) begin
      pre_limit <= merge_be(pre_limit, writedata, byteenable);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      match_ctrl <= 12'h000;
      capt_ctrl <= 12'h000;
    end else if (wr_take) begin
      // Only the low twelve bits of each per-channel control word are kept; the rest reads as zero.
      if (address == mct_pkg::OFF_MATCH_CTRL) begin
        match_ctrl <= 12'(merge_be({20'h0_0000, match_ctrl}, writedata, byteenable));
      end
      if (address == mct_pkg::OFF_CAPT_CTRL) begin
        capt_ctrl <= 12'(merge_be({20'h0_0000, capt_ctrl}, writedata, byteenable));
      end
    end
  end

  // Output levels: the match action wins over a software write of the level bit.
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_ctrl <= 12'h000;
    end else begin
      if (wr_take && address == mct_pkg::OFF_OUT_CTRL) begin
        out_ctrl <= 12'(merge_be({20'h0_0000, out_ctrl}, writedata, byteenable));
      end
      for (int i = 0; i < mct_pkg::NUM_CH; i++) begin
        if (hit[i]) begin
          case (out_ctrl[mct_pkg::OUT_ACT_BASE + i*mct_pkg::OUT_ACT_W +: mct_pkg::OUT_ACT_W])
            mct_pkg::ACT_LOW: out_ctrl[i] <= 1'b0;
            mct_pkg::ACT_HIGH: out_ctrl[i] <= 1'b1;
            mct_pkg::ACT_TOGGLE: out_ctrl[i] <= !out_ctrl[i];
            default: begin
            end
          endcase
        end
      end
    end
  end

  // The pins lag the level bits by one cycle so that they come straight from a flop.
  always_ff @(posedge mclk) begin
    if (rst) begin
      match_out <= '0;
    end else begin
      match_out <= out_ctrl[mct_pkg::NUM_CH-1:0];
    end
  end

  // Sticky request flags, write one to clear; a new event in the clearing cycle stays set.
  always_comb begin
    flag_set = '0;
    for (int i = 0; i < mct_pkg::NUM_CH; i++) begin
      flag_set[i] = hit[i] && match_ctrl[i*mct_pkg::CH_FIELD_W + mct_pkg::MC_IRQ];
      flag_set[mct_pkg::FLAG_CAPT_BASE + i] = capt_hit[i] &&
                                           capt_ctrl[i*mct_pkg::CH_FIELD_W + mct_pkg::CC_IRQ];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_req <= mct_pkg::RST_FLAGS;
    end else if (wr_take && address == mct_pkg::OFF_FLAGS && byteenable[0]) begin
      irq_req <= (irq_req & ~writedata[7:0]) | flag_set;
    end else begin
      irq_req <= irq_req | flag_set;
    end
  end

  // Read data are latched in the waiting cycle and stand while waitrequest is low.
  always_comb begin
    rd_mux = mct_pkg::RST_WORD;
    case (address)
      mct_pkg::OFF_CTRL: rd_mux = {26'h000_0000, ctrl.edge_fall, ctrl.edge_rise, 1'b0,
                                   ctrl.ext_count, ctrl.hold, ctrl.run};
      mct_pkg::OFF_FLAGS: rd_mux = {24'h00_0000, irq_req};
      mct_pkg::OFF_COUNT: rd_mux = count;
      mct_pkg::OFF_PRE_LIMIT: rd_mux = pre_limit;
      mct_pkg::OFF_PRE_COUNT: rd_mux = pre_count;
      mct_pkg::OFF_MATCH_CTRL: rd_mux = {20'h0_0000, match_ctrl};
      mct_pkg::OFF_CAPT_CTRL: rd_mux = {20'h0_0000, capt_ctrl};
      mct_pkg::OFF_OUT_CTRL: rd_mux = {20'h0_0000, out_ctrl};
      default: begin
        for (int i = 0; i < mct_pkg::NUM_CH; i++) begin
          if (address == mct_pkg::OFF_MATCH0 + 8'(i) * mct_pkg::OFF_STRIDE) begin
            rd_mux = match_val[i];
          end
          if (address == mct_pkg::OFF_CAPT0 + 8'(i) * mct_pkg::OFF_STRIDE) begin
            rd_mux = capt_val[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      readdata <= mct_pkg::RST_WORD;
    end else if (bus_take && read) begin
      readdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// >>> mct_pkg.sv
/*
  Shared constants and types of the match and capture timer/counter.
  Assumes a 32-bit Avalon-MM register bus with byte addresses and one clock domain.
*/
`default_nettype none
package mct_pkg;

  localparam int NUM_CH = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_PRE_LIMIT = 8'h0C;
  localparam logic [7:0] OFF_PRE_COUNT = 8'h10;
  localparam logic [7:0] OFF_MATCH_CTRL = 8'h14;
  localparam logic [7:0] OFF_CAPT_CTRL = 8'h18;
  localparam logic [7:0] OFF_OUT_CTRL = 8'h1C;
  localparam logic [7:0] OFF_MATCH0 = 8'h20;
  localparam logic [7:0] OFF_CAPT0 = 8'h30;
  localparam logic [7:0] OFF_STRIDE = 8'h04;

  // Control word layout.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_EXT = 2;
  localparam int CTRL_EDGE_RISE = 4;
  localparam int CTRL_EDGE_FALL = 5;

  // Per-channel fields: three bits per match channel and per capture channel.
  localparam int CH_FIELD_W = 3;
  localparam int MC_IRQ = 0;
  localparam int MC_RESET = 1;
  localparam int MC_STOP = 2;
  localparam int CC_RISE = 0;
  localparam int CC_FALL = 1;
  localparam int CC_IRQ = 2;

  // Output control: level bits low, then a two-bit action per channel.
  localparam int OUT_ACT_BASE = 4;
  localparam int OUT_ACT_W = 2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Event flag layout: matches in the low nibble, captures above.
  localparam int FLAG_CAPT_BASE = 4;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] ONE_WORD = 32'h0000_0001;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  typedef struct packed {
    logic edge_fall;
    logic edge_rise;
    logic ext_count;
    logic hold;
    logic run;
  } mct_ctrl_t;

  typedef enum logic [1:0] {
    MCT_BUS_IDLE = 2'b01,
    MCT_BUS_ANSWER = 2'b10
  } mct_bus_state_t;

endpackage
`default_nettype wire

// >>> mct_timer_sva.sv
/*
  Checker for the timer's bus handshake, read data and event flags.
  Assumes it is bound to every mct_timer instance and sees only its ports.
*/
`default_nettype none
module mct_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register bus
  input wire logic [mct_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [mct_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  // Event flags
  input wire logic [2*mct_pkg::NUM_CH-1:0] irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_one_wait;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("answer did not follow a request");
  property p_short_ans;
    !waitrequest |=> waitrequest;
  endproperty
  a_short_ans: assert property (p_short_ans)
    else $error("answer lasted more than one cycle");
  property p_ans_cause;
    $fell(waitrequest) |-> $past(read || write);
  endproperty
  a_ans_cause: assert property (p_ans_cause)
    else $error("answer without a request");
  property p_no_spurious;
    !waitrequest |-> (read || write);
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("answer while idle");
  property p_wait_rest;
    !(read || write) |=> waitrequest;
  endproperty
  a_wait_rest: assert property (p_wait_rest)
    else $error("waitrequest low at rest");
  property p_rd_when;
    !$past(rst) && $changed(readdata) |-> read && !waitrequest;
  endproperty
  a_rd_when: assert property (p_rd_when)
    else $error("read data changed outside a read answer");
  property p_unmapped;
    read && !waitrequest && address == 8'h40 |-> readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
  // Reset clears flags too, so the edge right after it is excused.
  property p_flag_clear;
    !$past(rst) && |($past(irq_req) & ~irq_req) |-> $past(write && !waitrequest && address == mct_pkg::OFF_FLAGS);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag dropped without a clearing write");
endmodule
bind mct_timer mct_chk u_chk (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .irq_req(irq_req));
`default_nettype wire

// >>> mct_pins.sv
/*
  Pin-side model: external count source and four capture sources.
  Assumes the timer synchronises these pins to mclk.
*/
`default_nettype none
module mct_pins (
  // Clock
  input wire logic mclk,
  // Pins
  output logic ext_count_in,
  output logic [3:0] capture_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_count_in = 1'b0;
    capture_in = 4'h0;
  end
  // Levels last four cycles so the three-stage synchronisers never lose an edge.
  task automatic count_pulses(input int n);
    repeat (n) begin
      ext_count_in <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_count_in <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  task automatic flip(input int ch);
    capture_in[ch] <= ~capture_in[ch];
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench of the match and capture timer.
  Assumes the pin model mct_pins and the bound checker are compiled alongside.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic [31:0] q;
  logic waitrequest;
  logic ext_count_in;
  logic [3:0] capture_in;
  logic [3:0] match_out;
  logic [7:0] irq_req;
  int fails = 0;
  int total_checks = 0;
  int seed = 32'hb845_2e58;
  int m;
  int lim;
  int n;
  always #4 mclk = ~mclk;
  mct_timer dut (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ext_count_in(ext_count_in), .capture_in(capture_in), .match_out(match_out), .irq_req(irq_req));
  mct_pins pins (.mclk(mclk), .ext_count_in(ext_count_in), .capture_in(capture_in));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= we;
    read <= ~we;
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, q);
  endtask
  function automatic logic [3:0] out_after(input logic [3:0] lvl, input logic [7:0] act);
    logic [3:0] r;
    r = lvl;
    for (int i = 0; i < 4; i++) begin
      case (act[2*i+:2])
        mct_pkg::ACT_LOW: r[i] = 1'b0;
        mct_pkg::ACT_HIGH: r[i] = 1'b1;
        mct_pkg::ACT_TOGGLE: r[i] = ~lvl[i];
        default: r[i] = lvl[i];
      endcase
    end
    return r;
  endfunction
  initial begin
    repeat (20000) @(posedge mclk);
    $display("Error watchdog expected done seen timeout");
    fails++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd_chk("count", mct_pkg::OFF_COUNT, 32'h0000_0000);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    bus(1'b1, mct_pkg::OFF_PRE_COUNT, 32'h0000_0005);
    rd_chk("prescale count", mct_pkg::OFF_PRE_COUNT, 32'h0000_0000);
    // All four matches share one value: channel 1 stops, 0 and 2 flag.
    m = 5 + ($random(seed) & 15);
    lim = $random(seed) & 3;
    for (int i = 0; i < 4; i++)
      bus(1'b1, mct_pkg::OFF_MATCH0 + 8'(4 * i), 32'(m));
    bus(1'b1, mct_pkg::OFF_PRE_LIMIT, 32'(lim));
    bus(1'b1, mct_pkg::OFF_MATCH_CTRL, 32'h0000_0061);
    bus(1'b1, mct_pkg::OFF_OUT_CTRL, 32'h0000_036a);
    @(posedge mclk);
    chk("levels", 32'h0000_000a, {28'h0, match_out});
    bus(1'b1, mct_pkg::OFF_CTRL, 32'h0000_0001);
    repeat ((m + 3) * (lim + 1) + 10) @(posedge mclk);
    rd_chk("stopped count", mct_pkg::OFF_COUNT, 32'(m));
    rd_chk("run bit", mct_pkg::OFF_CTRL, 32'h0000_0000);
    chk("match flags", 32'h0000_0005, {28'h0, irq_req[3:0]});
    chk("outputs", {28'h0, out_after(4'ha, 8'h36)}, {28'h0, match_out});
    bus(1'b1, mct_pkg::OFF_FLAGS, 32'h0000_00ff);
    chk("cleared", 32'h0000_0000, {24'h0, irq_req});
    bus(1'b1, mct_pkg::OFF_PRE_LIMIT, 32'h0000_0000);
    bus(1'b1, mct_pkg::OFF_MATCH_CTRL, 32'h0000_0002);
    bus(1'b1, mct_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (3 * m) @(posedge mclk);
    bus(1'b0, mct_pkg::OFF_COUNT, 32'h0000_0000);
    chk("wrapped", 32'h0000_0001, {31'h0, q <= 32'(m)});
    chk("silent match", 32'h0000_0000, {31'h0, irq_req[0]});
    bus(1'b1, mct_pkg::OFF_MATCH_CTRL, 32'h0000_0003);
    repeat (2 * m) @(posedge mclk);
    chk("reset flag", 32'h0000_0001, {31'h0, irq_req[0]});
    bus(1'b1, mct_pkg::OFF_CTRL, 32'h0000_0000);
    bus(1'b1, mct_pkg::OFF_MATCH_CTRL, 32'h0000_0000);
    bus(1'b1, mct_pkg::OFF_FLAGS, 32'h0000_00ff);
    bus(1'b1, mct_pkg::OFF_COUNT, 32'h0000_0000);
    bus(1'b1, mct_pkg::OFF_CTRL, 32'h0000_0015);
    n = 1 + ($random(seed) & 7);
    pins.count_pulses(n);
    repeat (6) @(posedge mclk);
    rd_chk("external count", mct_pkg::OFF_COUNT, 32'(n));
    bus(1'b1, mct_pkg::OFF_CAPT_CTRL, 32'h0000_0015);
    pins.flip(0);
    pins.flip(1);
    pins.flip(1);
    repeat (6) @(posedge mclk);
    rd_chk("capture 0", mct_pkg::OFF_CAPT0, 32'(n));
    rd_chk("capture 1", mct_pkg::OFF_CAPT0 + mct_pkg::OFF_STRIDE, 32'(n));
    chk("capture flags", 32'h0000_0010, {24'h0, irq_req});
    bus(1'b1, mct_pkg::OFF_CTRL, 32'h0000_0003);
    rd_chk("control", mct_pkg::OFF_CTRL, 32'h0000_0003);
    rd_chk("held count", mct_pkg::OFF_COUNT, 32'h0000_0000);
    rd_chk("held prescale", mct_pkg::OFF_PRE_COUNT, 32'h0000_0000);
    stop_test();
  end
endmodule
`default_nettype wire
